//--- shared/pldm_consts.vh
// Constants for the programmable logic macrocell block
`ifndef PLDM_CONSTS_VH
`define PLDM_CONSTS_VH
`define PLDM_IN_W 61
`define PLDM_PT_NUM 81
`define PLDM_WORDS 324
`define PLDM_PT_PB 0
`define PLDM_PT_PE 32
`define PLDM_PT_OE 64
`define PLDM_PT_PR 65
`define PLDM_PT_RE 66
`define PLDM_PT_PER 67
`define PLDM_PT_IRQA 79
`define PLDM_PT_IRQB 80
`define PLDM_A_CTRL 12'h000
`define PLDM_A_PBCFG 12'h004
`define PLDM_A_PBMODE 12'h008
`define PLDM_A_PECFG 12'h00C
`define PLDM_A_PEMODE 12'h010
`define PLDM_A_PERCFG 12'h014
`define PLDM_A_STATUS 12'h018
`define PLDM_A_PTIDX 12'h01C
`define PLDM_A_PTDATA 12'h020
`define PLDM_C_TURBO 0
`define PLDM_C_CLKDA 1
`define PLDM_C_CLKDC 2
`define PLDM_C_BUS0 3
`define PLDM_C_BUS1 4
`define PLDM_C_RSTEN 5
`define PLDM_CTRL_RST 6'h00
`define PLDM_CFG_RST 32'h00000000
`define PLDM_M_IN 2'h0
`define PLDM_M_OUT 2'h1
`define PLDM_M_BIDIR 2'h2
`define PLDM_M_BURIED 2'h3
`define PLDM_B_PB 8
`define PLDM_B_PE 16
`define PLDM_B_WDOG 44
`define PLDM_B_INTR 45
`define PLDM_B_INPUT_CLOCK_PIN 58
`define PLDM_B_RST 59
`define PLDM_ZP_NS 70
`define PLDM_CLK_NS 25
`endif

//--- rtl/pldm_macrocells.v
// Macrocell fabric: product term array, port B/E and peripheral cells
// Behaviour
// - Array sees true and complement of 61 inputs
// - Port B preset only when term defined
// - Port B clear: reset pin or term
// - Port B clock: clock pin or term
// - Eight port E cells, one pin each
// - Port E shared enable, preset, clear terms
// - Port E clocked by pin, cleared by term or by reset when enabled
// - Port E cell: four terms, selectable polarity
// - Registered/combinational output; pin mode select
// - Feedback registered or combinational expander
// - Buried cell leaves its pin free
// - PE0/PE1 bus control replaces feedback
// - Optional configurable reset clears port E
// - Six peripheral cells: four timer, two irq
// - Timer controls muxed with timer pins
// - Four interrupt requests from cells and terms
// - Watchdog and irq feedback enter array
// - Peripheral cell: two terms, reg/comb, polarity
// - Peripheral registers clocked by pin, reset cleared
// - Zero power only with turbo cleared
// - Idle inputs 70ns give minimal-current state
// - Clock to array or cells can be disabled
`timescale 1ns/1ps
`include "pldm_consts.vh"
module pldm_macrocells (
    input  wire        clock,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        inputClockPin,
    input  wire        resetPin,
    input  wire [7:0]  portAIn,
    input  wire [7:0]  portBIn,
    output wire [7:0]  portBOut,
    output wire [7:0]  portBOe,
    input  wire [7:0]  portCIn,
    input  wire [7:0]  portDIn,
    input  wire [7:0]  portEIn,
    output wire [7:0]  portEOut,
    output wire [7:0]  portEOe,
    input  wire [3:0]  pageReg,
    input  wire [9:0]  mcuAddr,
    input  wire        mcuRead,
    input  wire        mcuWrite,
    input  wire        chipSelIn,
    input  wire        watchdogFeedback,
    input  wire        irqControllerFeedback,
    input  wire [3:0]  timerPinIn,
    output wire [3:0]  cellToTimerControls,
    output wire [3:0]  irqRequests,
    output wire        zeroPowerState
);

    localparam [31:0] ZP_FULL = (`PLDM_ZP_NS + `PLDM_CLK_NS - 1) / `PLDM_CLK_NS;
    localparam [1:0]  ZP_CYC  = ZP_FULL[1:0];

    // Output select and polarity, shared by all cell kinds
    function cellOut;
        input q;
        input comb;
        input regSel;
        input pol;
        begin
            cellOut = (regSel ? q : comb) ^ pol;
        end
    endfunction

    // Clear first, then preset, then a clock edge loads
    function cellNext;
        input q;
        input d;
        input edgeHit;
        input pre;
        input clr;
        begin
            if (clr) begin
                cellNext = 1'b0;
            end else if (pre) begin
                cellNext = 1'b1;
            end else if (edgeHit) begin
                cellNext = d;
            end else begin
                cellNext = q;
            end
        end
    endfunction

    reg  [5:0]  ctrl_reg;
    reg  [31:0] pbCfg_reg;
    reg  [23:0] pbMode_reg;
    reg  [23:0] peCfg_reg;
    reg  [15:0] peMode_reg;
    reg  [15:0] perCfg_reg;
    reg  [8:0]  ptIdx_reg;
    reg  [31:0] ptMem [0:`PLDM_WORDS-1];
    reg  [60:0] inBus_reg;
    reg         clkPrev_reg;
    reg  [7:0]  pbQ_reg;
    reg  [7:0]  pbClkPrev_reg;
    reg  [7:0]  peQ_reg;
    reg  [5:0]  perQ_reg;
    reg  [1:0]  zpCnt_reg;

    wire [60:0] inBus_next;
    wire [80:0] pt;
    wire [7:0]  pbNext;
    wire [7:0]  pbOut;
    wire [7:0]  pbFb;
    wire [7:0]  pbLoad;
    wire [7:0]  peNext;
    wire [7:0]  peOut;
    wire [7:0]  peFb;
    wire [7:0]  peLoad;
    wire [5:0]  perNext;
    wire [5:0]  perOut;
    wire [7:0]  busMask;
    wire        cellClkOn;
    wire        clkEdge;
    wire        cellReset;
    wire        inChange;
    wire        apbAcc;
    wire        apbWr;
    wire        addrHit;
    wire        idxOk;
    integer     w;

    assign cellClkOn = ~ctrl_reg[`PLDM_C_CLKDC];
    assign clkEdge   = inputClockPin & ~clkPrev_reg & cellClkOn;
    assign cellReset = resetPin & ctrl_reg[`PLDM_C_RSTEN];
    assign busMask   = {6'h00, ctrl_reg[`PLDM_C_BUS1], ctrl_reg[`PLDM_C_BUS0]};

    // Registered input bus breaks the loop through expander feedback
    assign inBus_next = {chipSelIn,
                         resetPin,
                         inputClockPin & ~ctrl_reg[`PLDM_C_CLKDA],
                         mcuWrite,
                         mcuRead,
                         mcuAddr,
                         irqControllerFeedback,
                         watchdogFeedback,
                         pageReg,
                         portDIn,
                         portCIn,
                         peLoad,
                         pbLoad,
                         portAIn};

    // An empty term reads inactive, so undefined presets never fire
    genvar g;
    generate
        for (g = 0; g < `PLDM_PT_NUM; g = g + 1) begin : gTerm
            wire [60:0] maskT = {ptMem[4*g+1][28:0], ptMem[4*g]};
            wire [60:0] maskC = {ptMem[4*g+3][28:0], ptMem[4*g+2]};
            assign pt[g] = (|maskT | |maskC) &
                           ~|((maskT & ~inBus_reg) | (maskC & inBus_reg));
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : gPortB
            wire       d     = pt[`PLDM_PT_PB+4*i];
            wire       pre   = pt[`PLDM_PT_PB+4*i+1];
            wire       clrPt = pt[`PLDM_PT_PB+4*i+2];
            wire       clkPt = pt[`PLDM_PT_PB+4*i+3];
            wire [1:0] mode  = pbMode_reg[2*i+1:2*i];
            wire       clr   = pbCfg_reg[8+i] ? clrPt : resetPin;
            wire       hit   = pbCfg_reg[i] ?
                               (clkPt & ~pbClkPrev_reg[i] & cellClkOn) : clkEdge;
            assign pbNext[i] = cellNext(pbQ_reg[i], d, hit, pre, clr);
            assign pbOut[i]  = cellOut(pbQ_reg[i], d, pbCfg_reg[16+i], pbCfg_reg[24+i]);
            assign pbFb[i]   = pbMode_reg[16+i] ? d : pbQ_reg[i];
            assign pbLoad[i] = (mode == `PLDM_M_IN || mode == `PLDM_M_BIDIR) ?
                               portBIn[i] : pbFb[i];
            assign portBOe[i] = (mode == `PLDM_M_OUT) ||
                                (mode == `PLDM_M_BIDIR && pt[`PLDM_PT_OE]);
        end
    endgenerate
    assign portBOut = pbOut;

    generate
        for (i = 0; i < 8; i = i + 1) begin : gPortE
            wire       d    = |pt[`PLDM_PT_PE+4*i +: 4];
            wire [1:0] mode = peMode_reg[2*i+1:2*i];
            wire       clr  = pt[`PLDM_PT_RE] | cellReset;
            assign peNext[i] = cellNext(peQ_reg[i], d, clkEdge, pt[`PLDM_PT_PR], clr);
            assign peOut[i]  = cellOut(peQ_reg[i], d, peCfg_reg[i], peCfg_reg[8+i]);
            assign peFb[i]   = peCfg_reg[16+i] ? d : peQ_reg[i];
            // Bus control pins feed the pin into the array and keep the output driver off
            assign peLoad[i] = (busMask[i] || mode == `PLDM_M_IN ||
                                mode == `PLDM_M_BIDIR) ? portEIn[i] : peFb[i];
            assign portEOe[i] = ~busMask[i] && pt[`PLDM_PT_OE] &&
                                (mode == `PLDM_M_OUT || mode == `PLDM_M_BIDIR);
        end
    endgenerate
    assign portEOut = peOut;

    generate
        for (i = 0; i < 6; i = i + 1) begin : gPeriph
            wire d = pt[`PLDM_PT_PER+2*i] | pt[`PLDM_PT_PER+2*i+1];
            assign perNext[i] = cellNext(perQ_reg[i], d, clkEdge, 1'b0, resetPin);
            assign perOut[i]  = cellOut(perQ_reg[i], d, perCfg_reg[i], perCfg_reg[6+i]);
        end
        for (i = 0; i < 4; i = i + 1) begin : gTimer
            assign cellToTimerControls[i] = perCfg_reg[12+i] ?
                                            perOut[i] : timerPinIn[i];
        end
    endgenerate

    assign irqRequests = {pt[`PLDM_PT_IRQB], pt[`PLDM_PT_IRQA], perOut[5], perOut[4]};

    // Zero power is reported only; logic values never change with it
    assign inChange = (inBus_next != inBus_reg);
    assign zeroPowerState = ~ctrl_reg[`PLDM_C_TURBO] && ~inChange &&
                            (zpCnt_reg == ZP_CYC);

    assign apbAcc  = psel & penable;
    assign apbWr   = apbAcc & pwrite;
    assign idxOk   = (ptIdx_reg < `PLDM_WORDS);
    assign pready  = 1'b1;
    assign addrHit = (paddr == `PLDM_A_CTRL) || (paddr == `PLDM_A_PBCFG) ||
                     (paddr == `PLDM_A_PBMODE) || (paddr == `PLDM_A_PECFG) ||
                     (paddr == `PLDM_A_PEMODE) || (paddr == `PLDM_A_PERCFG) ||
                     (paddr == `PLDM_A_STATUS) || (paddr == `PLDM_A_PTIDX) ||
                     (paddr == `PLDM_A_PTDATA);
    assign pslverr = apbAcc & ~addrHit;

    always @* begin
        prdata = 32'h00000000;
        case (paddr)
            `PLDM_A_CTRL: begin
                prdata = {26'h0000000, ctrl_reg};
            end
            `PLDM_A_PBCFG: begin
                prdata = pbCfg_reg;
            end
            `PLDM_A_PBMODE: begin
                prdata = {8'h00, pbMode_reg};
            end
            `PLDM_A_PECFG: begin
                prdata = {8'h00, peCfg_reg};
            end
            `PLDM_A_PEMODE: begin
                prdata = {16'h0000, peMode_reg};
            end
            `PLDM_A_PERCFG: begin
                prdata = {16'h0000, perCfg_reg};
            end
            `PLDM_A_STATUS: begin
                prdata = {9'h000, zeroPowerState, perQ_reg, peQ_reg, pbQ_reg};
            end
            `PLDM_A_PTIDX: begin
                prdata = {23'h000000, ptIdx_reg};
            end
            `PLDM_A_PTDATA: begin
                prdata = idxOk ? ptMem[ptIdx_reg] : 32'h00000000;
            end
            default: begin
                prdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            ctrl_reg      <= `PLDM_CTRL_RST;
            pbCfg_reg     <= `PLDM_CFG_RST;
            pbMode_reg    <= 24'h000000;
            peCfg_reg     <= 24'h000000;
            peMode_reg    <= 16'h0000;
            perCfg_reg    <= 16'h0000;
            ptIdx_reg     <= 9'h000;
            inBus_reg     <= 61'h0;
            clkPrev_reg   <= 1'b0;
            pbQ_reg       <= 8'h00;
            pbClkPrev_reg <= 8'h00;
            peQ_reg       <= 8'h00;
            perQ_reg      <= 6'h00;
            zpCnt_reg     <= 2'h0;
            for (w = 0; w < `PLDM_WORDS; w = w + 1) begin
                ptMem[w] <= 32'h00000000;
            end
        end else begin
            inBus_reg     <= inBus_next;
            clkPrev_reg   <= inputClockPin;
            pbClkPrev_reg <= {pt[31], pt[27], pt[23], pt[19], pt[15], pt[11], pt[7], pt[3]};
            pbQ_reg       <= pbNext;
            peQ_reg       <= peNext;
            perQ_reg      <= perNext;
            if (inChange || ctrl_reg[`PLDM_C_TURBO]) begin
                zpCnt_reg <= 2'h0;
            end else if (zpCnt_reg != ZP_CYC) begin
                zpCnt_reg <= zpCnt_reg + 2'h1;
            end
            if (apbWr) begin
                case (paddr)
                    `PLDM_A_CTRL: begin
                        ctrl_reg <= pwdata[5:0];
                    end
                    `PLDM_A_PBCFG: begin
                        pbCfg_reg <= pwdata;
                    end
                    `PLDM_A_PBMODE: begin
                        pbMode_reg <= pwdata[23:0];
                    end
                    `PLDM_A_PECFG: begin
                        peCfg_reg <= pwdata[23:0];
                    end
                    `PLDM_A_PEMODE: begin
                        peMode_reg <= pwdata[15:0];
                    end
                    `PLDM_A_PERCFG: begin
                        perCfg_reg <= pwdata[15:0];
                    end
                    `PLDM_A_PTIDX: begin
                        ptIdx_reg <= pwdata[8:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Index steps after every data access for burst loading
            if (apbAcc && paddr == `PLDM_A_PTDATA) begin
                if (pwrite && idxOk) begin
                    ptMem[ptIdx_reg] <= pwdata;
                end
                ptIdx_reg <= ptIdx_reg + 9'h001;
            end
        end
    end

endmodule

//--- tb/pldm_macrocells_props.sv
// Port assertions for the macrocell fabric
`timescale 1ns/1ps
module pldm_macrocells_props (
    input wire        clock,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [7:0]  portAIn,
    input wire [7:0]  portBOe,
    input wire [7:0]  portEOe,
    input wire [3:0]  timerPinIn,
    input wire [3:0]  cellToTimerControls,
    input wire [3:0]  irqRequests,
    input wire        zeroPowerState
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_PREADY_NOW: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr > 12'h020
        |-> pslverr && prdata == 32'h00000000) else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (psel && penable && paddr <= 12'h020
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
    AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside access phase");
    AST_RST_OUT: assert property ($fell(rst) |->
        portEOe == 8'h00 && portBOe == 8'h00 && irqRequests == 4'h0)
        else $error("outputs not quiet after reset");
    AST_RST_TIMER: assert property ($fell(rst) |->
        cellToTimerControls == timerPinIn) else $error("timer controls not from pins");
    AST_ZP_CHANGE: assert property ($changed(portAIn) |=> !zeroPowerState)
        else $error("idle state kept across input change");
    AST_ZP_RST: assert property ($fell(rst) |-> !zeroPowerState ##1 !zeroPowerState)
        else $error("idle state too early after reset");
endmodule
bind pldm_macrocells pldm_macrocells_props chk (.*);

//--- tb/pldm_periph_model.sv
// Timer and interrupt controller side, one cycle of delay
`timescale 1ns/1ps
module pldm_periph_model (
    input  wire       clock,
    input  wire       wdogReq,
    input  wire       irqReq,
    input  wire [3:0] pinReq,
    output reg        watchdogFeedback = 1'b0,
    output reg        irqControllerFeedback = 1'b0,
    output reg  [3:0] timerPinIn = 4'h0
);
    always @(posedge clock) begin
        watchdogFeedback <= wdogReq;
        irqControllerFeedback <= irqReq;
        timerPinIn <= pinReq;
    end
endmodule

//--- tb/tb.sv
// Self-checking bench for the macrocell fabric
`timescale 1ns/1ps
`include "pldm_consts.vh"
module tb;
    reg         clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000, rdv;
    reg         inputClockPin = 1'b0, resetPin = 1'b0, mcuRead = 1'b0, mcuWrite = 1'b0;
    reg  [7:0]  portAIn = 8'h00, portBIn = 8'h00, portCIn = 8'h00;
    reg  [7:0]  portDIn = 8'h00, portEIn = 8'h00;
    reg  [3:0]  pageReg = 4'h0, pinReq = 4'h0;
    reg  [9:0]  mcuAddr = 10'h000;
    reg         chipSelIn = 1'b0, wdogReq = 1'b0, irqReq = 1'b0, rde;
    wire [31:0] prdata;
    wire        pready, pslverr, watchdogFeedback, irqControllerFeedback, zeroPowerState;
    wire [7:0]  portBOut, portBOe, portEOut, portEOe;
    wire [3:0]  timerPinIn, cellToTimerControls, irqRequests;
    integer     mismatches = 0;
    integer     check_count = 0;
    integer     i;
    pldm_macrocells uut (.*);
    pldm_periph_model far (.clock(clock), .wdogReq(wdogReq), .irqReq(irqReq),
        .pinReq(pinReq), .watchdogFeedback(watchdogFeedback),
        .irqControllerFeedback(irqControllerFeedback), .timerPinIn(timerPinIn));
    initial forever #12.5 clock = ~clock;
    task test_done;
        begin
            if (mismatches == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Idle edge first, so psel is never assigned twice in one step
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            @(posedge clock);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clock);
            end
            if (n == 20) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t bus wait timeout", $time);
                test_done;
            end
            rdv = prdata;
            rde = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input [11:0] a, input [31:0] e, input err);
        begin
            apb(1'b0, a, 32'h00000000);
            cmp(rdv, e);
            cmp({31'h0, rde}, {31'h0, err});
        end
    endtask
    // One literal per term: input b, true (c=0) or complement (c=1)
    task term(input [6:0] p, input [5:0] b, input c);
        reg [127:0] m;
        integer k;
        begin
            m = 128'h0;
            m[{c, b}] = 1'b1;
            wr(`PLDM_A_PTIDX, {23'h0, p, 2'b00});
            for (k = 0; k < 4; k = k + 1)
                wr(`PLDM_A_PTDATA, m[32 * k +: 32]);
        end
    endtask
    task pulse;
        begin
            repeat (3) @(posedge clock);
            inputClockPin <= 1'b1;
            repeat (3) @(posedge clock);
            inputClockPin <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask
    initial begin
        rdv = $urandom(72516);
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (i = 0; i < 6; i = i + 1)
            rd({i[9:0], 2'b00}, 32'h00000000, 1'b0);
        wr(`PLDM_A_PTIDX, 32'h00000005);
        rd(`PLDM_A_PTDATA, 32'h00000000, 1'b0);
        rd(`PLDM_A_PTIDX, 32'h00000006, 1'b0);
        wr(`PLDM_A_PTIDX, 32'h00000144);
        wr(`PLDM_A_PTDATA, 32'hFFFFFFFF);
        wr(`PLDM_A_PTIDX, 32'h00000144);
        rd(`PLDM_A_PTDATA, 32'h00000000, 1'b0);
        wr(12'h024, 32'hFFFFFFFF);
        rd(12'h024, 32'h00000000, 1'b1);
        rd(12'hFFC, 32'h00000000, 1'b1);
        term(7'h4F, 6'h2C, 1'b0);
        term(7'h50, 6'h2D, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            {wdogReq, irqReq, pinReq, portCIn, portDIn, mcuAddr} <= $urandom;
            rdv = $urandom;
            {pageReg, mcuRead, mcuWrite, portBIn} <= rdv[13:0];
            repeat (5) @(posedge clock);
            cmp(irqRequests, {~irqReq, wdogReq, 2'b00});
            cmp(cellToTimerControls, pinReq);
        end
        term(7'h43, 6'h00, 1'b0);
        term(7'h4B, 6'h01, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`PLDM_A_PERCFG, i[0] ? 32'h00001040 : 32'h00001000);
            portAIn <= 8'($urandom);
            repeat (4) @(posedge clock);
            cmp({irqRequests[0], cellToTimerControls},
                {portAIn[1], pinReq[3:1], portAIn[0] ^ i[0]});
        end
        wr(`PLDM_A_PERCFG, 32'h00001001);
        portAIn <= 8'h01;
        pulse;
        portAIn <= 8'h00;
        repeat (4) @(posedge clock);
        cmp(cellToTimerControls[0], 1'b1);
        pulse;
        cmp(cellToTimerControls[0], 1'b0);
        wr(`PLDM_A_CTRL, 32'h00000020);
        term(7'h40, 6'h3C, 1'b1);
        term(7'h20, 6'h01, 1'b0);
        wr(`PLDM_A_PEMODE, 32'h00000001);
        portAIn <= 8'h02;
        repeat (4) @(posedge clock);
        cmp({portEOe[0], portEOut[0]}, 2'h3);
        wr(`PLDM_A_PECFG, 32'h00000001);
        pulse;
        portAIn <= 8'h00;
        repeat (4) @(posedge clock);
        cmp(portEOut[0], 1'b1);
        resetPin <= 1'b1;
        repeat (4) @(posedge clock);
        cmp(portEOut[0], 1'b0);
        resetPin <= 1'b0;
        term(7'h41, 6'h02, 1'b0);
        portAIn <= 8'h04;
        repeat (4) @(posedge clock);
        cmp(portEOut[0], 1'b1);
        resetPin <= 1'b1;
        repeat (4) @(posedge clock);
        cmp(portEOut[0], 1'b0);
        resetPin <= 1'b0;
        portAIn <= 8'h00;
        wr(`PLDM_A_PEMODE, 32'h00000003);
        @(posedge clock);
        cmp(portEOe[0], 1'b0);
        wr(`PLDM_A_CTRL, 32'h00000028);
        wr(`PLDM_A_PEMODE, 32'h00000001);
        term(7'h4F, 6'h10, 1'b0);
        portEIn <= 8'h01;
        repeat (4) @(posedge clock);
        cmp({portEOe[0], irqRequests[2]}, 2'h1);
        portEIn <= 8'h00;
        resetPin <= 1'b1;
        repeat (4) @(posedge clock);
        resetPin <= 1'b0;
        term(7'h50, 6'h08, 1'b0);
        term(7'h00, 6'h03, 1'b0);
        wr(`PLDM_A_PBCFG, 32'h00010000);
        wr(`PLDM_A_PBMODE, 32'h00000001);
        portAIn <= 8'h08;
        pulse;
        cmp(portBOut[0], 1'b1);
        resetPin <= 1'b1;
        repeat (4) @(posedge clock);
        cmp(portBOut[0], 1'b0);
        resetPin <= 1'b0;
        term(7'h03, 6'h04, 1'b0);
        wr(`PLDM_A_PBCFG, 32'h00010001);
        pulse;
        cmp(portBOut[0], 1'b0);
        portAIn <= 8'h18;
        repeat (4) @(posedge clock);
        cmp({portBOut[0], irqRequests[3]}, 2'h3);
        wr(`PLDM_A_PBMODE, 32'h00010001);
        portAIn <= 8'h10;
        repeat (4) @(posedge clock);
        cmp({portBOut[0], irqRequests[3], portBOe[0]}, 3'h5);
        wr(`PLDM_A_CTRL, 32'h00000000);
        repeat (6) @(posedge clock);
        cmp(zeroPowerState, 1'b1);
        chipSelIn <= 1'b1;
        repeat (2) @(posedge clock);
        cmp(zeroPowerState, 1'b0);
        wr(`PLDM_A_CTRL, 32'h00000001);
        repeat (6) @(posedge clock);
        cmp(zeroPowerState, 1'b0);
        wr(`PLDM_A_CTRL, 32'h00000002);
        repeat (6) @(posedge clock);
        inputClockPin <= 1'b1;
        repeat (2) @(posedge clock);
        cmp(zeroPowerState, 1'b1);
        wr(`PLDM_A_CTRL, 32'h00000000);
        repeat (6) @(posedge clock);
        inputClockPin <= 1'b0;
        repeat (2) @(posedge clock);
        cmp(zeroPowerState, 1'b0);
        test_done;
    end
endmodule
